// [verilog/port_io_pkg.sv]
// Constants, types and register map for the four-port I/O block
package port_io_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT0 = 8'h00;
  localparam logic [7:0] ADDR_PORT1 = 8'h04;
  localparam logic [7:0] ADDR_PORT2 = 8'h08;
  localparam logic [7:0] ADDR_PORT3 = 8'h0c;
  localparam logic [7:0] ADDR_DIRCFG = 8'h10;
  localparam logic [7:0] ADDR_HWCFG = 8'h14;
  localparam logic [7:0] ADDR_ALTCFG = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_MEMORY_PAGE_REGISTER = 8'h20;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_RESET = 8'hff;
  localparam logic [3:0] DIRCFG_RESET = 4'hf;
  localparam logic [1:0] HWCFG_RESET = 2'h0;
  localparam logic [11:0] ALTCFG_RESET = 12'h000;
  localparam logic [7:0] MEMORY_PAGE_REGISTER_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int HW_MEM_ENABLE = 0;
  localparam int HW_P0_BUS = 1;
  localparam int ALT_T2_CTR = 0;
  localparam int ALT_T2_RELOAD = 1;
  localparam int ALT_T2_EXEN = 2;
  localparam int ALT_SER1 = 3;
  localparam int ALT_SER0 = 4;
  localparam int ALT_PWM = 5;
  localparam int ALT_IRQ0_EDGE = 6;
  localparam int ALT_IRQ1_EDGE = 7;
  localparam int ALT_T0_CTR = 8;
  localparam int ALT_T1_CTR = 9;
  localparam int ALT_T0_EDGE = 10;
  localparam int ALT_T1_EDGE = 11;
  localparam int STAT_T2_FLAG = 0;
  localparam int STAT_BUSY = 1;

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam logic [2:0] DATA_CYCLES = 3'd6;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {BUS_IDLE, BUS_ADDR, BUS_LATCH, BUS_DATA}
    busState_e;

  typedef struct packed {
    logic go;
    logic write;
    logic fetch;
    logic viaDptr;
    logic [7:0] addrHigh;
    logic [7:0] addrLow;
    logic [7:0] wdata;
  } memReq_s;

  typedef struct packed {
    logic primaryTx;
    logic secondaryTx;
    logic pwm;
  } altOut_s;

  typedef struct packed {
    logic t2Count;
    logic t2Reload;
    logic t0Inc;
    logic t1Inc;
    logic irq0;
    logic irq1;
    logic irq2;
    logic irq3;
    logic irq4;
    logic irq5;
    logic primaryRx;
    logic secondaryRx;
    logic spiSelect;
    logic spiMosi;
    logic spiMiso;
    logic spiClock;
  } pinEvents_s;

endpackage

// [verilog/quad_port_io.sv]
// Four 8-bit I/O ports with alternate functions and external bus
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

// Operation
// RULE_01: Pins follow written port register bits
// RULE_02: Port read returns present pin levels
// RULE_03: Pull-ups only in compatibility mode
// RULE_04: Pull-ups off otherwise and during bus
// RULE_05: Port 0 multiplexes low address and data
// RULE_06: Port 0 general I/O only when bus idle
// RULE_07: Code fetch takes port 0 continuously
// RULE_08: Counter select: pin 1.0 falls count timer2
// RULE_09: Pin 1.1 fall reloads timer2, sets flag
// RULE_10: Pins 1.2/1.3 carry secondary serial lines
// RULE_11: Pin 1.4 rise raises irq two; SPI select
// RULE_12: Falls on 1.5, 1.7 raise irq three, five
// RULE_13: Pin 1.6 rise raises irq four; SPI MISO
// RULE_14: Memory enable gives port 2 high address
// RULE_15: Port 2 takes pointer high or page
// RULE_16: Port 2 fetch addresses only with enable
// RULE_17: Pins 3.0/3.1 carry primary serial lines
// RULE_18: Pins 3.2/3.3 irq zero/one, level or edge
// RULE_19: Pins 3.4/3.5 count timers, gate or edge
// RULE_20: Pin 3.6 low writes external RAM
// RULE_21: Pin 3.7 low reads external RAM
// RULE_22: Reset restores all registers to defaults
// RULE_23: Address stands on port 0 at ALE fall
// RULE_24: Idle pins follow register; inputs synchronised
module quad_port_io (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port pins
  input wire logic [3:0][7:0] pinIn,
  output logic [3:0][7:0] pinOut,
  output logic [3:0][7:0] pinOeN,
  output logic [3:0] pullupEn,
  output logic ale,
  // Core external memory side
  input wire port_io_pkg::memReq_s memReq,
  output logic memBusy,
  output logic memDone,
  output logic [7:0] memRdata,
  // Peripheral side
  input wire port_io_pkg::altOut_s altOut,
  output port_io_pkg::pinEvents_s pinEvents
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [3:0][7:0] portReg_q;
  logic [3:0] dirCfg_q;
  logic [1:0] hwCfg_q;
  logic [11:0] altCfg_q;
  logic [7:0] memory_page_register_q;
  logic t2Flag_q;
  logic [31:0] prdata_q;
  logic [3:0][7:0] sync1_q, sync2_q, sync3_q, lvl_q, lvl_d;
  logic [3:0][7:0] rise, fall;
  port_io_pkg::busState_e state_q;
  logic [2:0] cnt_q;
  port_io_pkg::memReq_s hold_q;
  logic done_q;
  logic [7:0] rdata_q;
  logic [3:0][7:0] out_d, oeN_d, out_q, oeN_q;
  logic [3:0] pull_d, pull_q;
  logic ale_d, ale_q;
  port_io_pkg::pinEvents_s ev_d, ev_q;
  logic access, wrEn, memEn, busEn, strobe;

  // Address decode shared by error answer and write enable
  function automatic logic regHit(input logic [7:0] a);
    regHit = a == port_io_pkg::ADDR_PORT0 ||
             a == port_io_pkg::ADDR_PORT1 ||
             a == port_io_pkg::ADDR_PORT2 ||
             a == port_io_pkg::ADDR_PORT3 ||
             a == port_io_pkg::ADDR_DIRCFG ||
             a == port_io_pkg::ADDR_HWCFG ||
             a == port_io_pkg::ADDR_ALTCFG ||
             a == port_io_pkg::ADDR_STATUS ||
             a == port_io_pkg::ADDR_MEMORY_PAGE_REGISTER;
  endfunction

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero wait states; read data captured in the setup cycle
  assign access = psel & penable;
  assign wrEn = access & pwrite & regHit(paddr);
  assign pready = 1'b1;
  assign pslverr = access & ~regHit(paddr);
  assign prdata = prdata_q;
  assign memEn = hwCfg_q[port_io_pkg::HW_MEM_ENABLE];
  assign busEn = hwCfg_q[port_io_pkg::HW_P0_BUS];

  // Read mux, port reads show the synchronised pin levels
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable)
    begin
      case (paddr)
        port_io_pkg::ADDR_PORT0: prdata_q <= {24'h0, lvl_q[0]}; // [RULE_02]
        port_io_pkg::ADDR_PORT1: prdata_q <= {24'h0, lvl_q[1]}; // [RULE_02]
        port_io_pkg::ADDR_PORT2: prdata_q <= {24'h0, lvl_q[2]}; // [RULE_02]
        port_io_pkg::ADDR_PORT3: prdata_q <= {24'h0, lvl_q[3]}; // [RULE_02]
        port_io_pkg::ADDR_DIRCFG: prdata_q <= {28'h0, dirCfg_q};
        port_io_pkg::ADDR_HWCFG: prdata_q <= {30'h0, hwCfg_q};
        port_io_pkg::ADDR_ALTCFG: prdata_q <= {20'h0, altCfg_q};
        port_io_pkg::ADDR_STATUS:
          prdata_q <= {30'h0, state_q != port_io_pkg::BUS_IDLE, t2Flag_q};
        port_io_pkg::ADDR_MEMORY_PAGE_REGISTER: prdata_q <= {24'h0, memory_page_register_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Software registers, all back to defaults on reset
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      portReg_q <= {4{port_io_pkg::PORT_RESET}}; // [RULE_22]
      dirCfg_q <= port_io_pkg::DIRCFG_RESET;
      hwCfg_q <= port_io_pkg::HWCFG_RESET;
      altCfg_q <= port_io_pkg::ALTCFG_RESET;
      memory_page_register_q <= port_io_pkg::MEMORY_PAGE_REGISTER_RESET;
    end
    else if (wrEn)
    begin
      case (paddr)
        port_io_pkg::ADDR_PORT0: portReg_q[0] <= pwdata[7:0];
        port_io_pkg::ADDR_PORT1: portReg_q[1] <= pwdata[7:0];
        port_io_pkg::ADDR_PORT2: portReg_q[2] <= pwdata[7:0];
        port_io_pkg::ADDR_PORT3: portReg_q[3] <= pwdata[7:0];
        port_io_pkg::ADDR_DIRCFG: dirCfg_q <= pwdata[3:0];
        port_io_pkg::ADDR_HWCFG: hwCfg_q <= pwdata[1:0];
        port_io_pkg::ADDR_ALTCFG: altCfg_q <= pwdata[11:0];
        port_io_pkg::ADDR_MEMORY_PAGE_REGISTER: memory_page_register_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Reload flag: hardware set wins over a write-one clear
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      t2Flag_q <= 1'b0;
    else if (ev_d.t2Reload)
      t2Flag_q <= 1'b1; // [RULE_09]
    else if (wrEn && paddr == port_io_pkg::ADDR_STATUS &&
             pwdata[port_io_pkg::STAT_T2_FLAG])
      t2Flag_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Pin input synchroniser and edge detection
  // ----------------------------------------------------------------
  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_q <= '1;
      sync2_q <= '1;
      sync3_q <= '1;
      lvl_q <= '1;
    end
    else
    begin
      sync1_q <= pinIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      lvl_q <= lvl_d; // [RULE_24]
    end
  end

  assign lvl_d = (~(sync2_q ^ sync3_q) & sync3_q) |
                 ((sync2_q ^ sync3_q) & lvl_q);
  assign rise = ~lvl_q & lvl_d;
  assign fall = lvl_q & ~lvl_d;

  // Alternate input functions, registered toward the peripherals
  always_comb
  begin
    ev_d.t2Count = altCfg_q[port_io_pkg::ALT_T2_CTR] & fall[1][0]; // [RULE_08]
    ev_d.t2Reload = altCfg_q[port_io_pkg::ALT_T2_RELOAD] &
                    altCfg_q[port_io_pkg::ALT_T2_EXEN] & fall[1][1]; // [RULE_09]
    ev_d.secondaryRx = lvl_d[1][2]; // [RULE_10]
    ev_d.irq2 = rise[1][4]; // [RULE_11]
    ev_d.spiSelect = lvl_d[1][4]; // [RULE_11]
    ev_d.irq3 = fall[1][5]; // [RULE_12]
    ev_d.spiMosi = lvl_d[1][5]; // [RULE_12]
    ev_d.irq4 = rise[1][6]; // [RULE_13]
    ev_d.spiMiso = lvl_d[1][6]; // [RULE_13]
    ev_d.irq5 = fall[1][7]; // [RULE_12]
    ev_d.spiClock = lvl_d[1][7]; // [RULE_12]
    ev_d.primaryRx = lvl_d[3][0]; // [RULE_17]
    // Level mode asserts while the pin is low
    ev_d.irq0 = altCfg_q[port_io_pkg::ALT_IRQ0_EDGE] ? fall[3][2]
                                                      : ~lvl_d[3][2]; // [RULE_18]
    ev_d.irq1 = altCfg_q[port_io_pkg::ALT_IRQ1_EDGE] ? fall[3][3]
                                                      : ~lvl_d[3][3]; // [RULE_18]
    // Gate mode counts every cycle high, edge mode each fall
    ev_d.t0Inc = altCfg_q[port_io_pkg::ALT_T0_CTR] &
                 (altCfg_q[port_io_pkg::ALT_T0_EDGE] ? fall[3][4]
                                                     : lvl_d[3][4]); // [RULE_19]
    ev_d.t1Inc = altCfg_q[port_io_pkg::ALT_T1_CTR] &
                 (altCfg_q[port_io_pkg::ALT_T1_EDGE] ? fall[3][5]
                                                     : lvl_d[3][5]); // [RULE_19]
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      ev_q <= '0;
    else
      ev_q <= ev_d;
  end

  assign pinEvents = ev_q;

  // ----------------------------------------------------------------
  // External memory bus sequencer
  // ----------------------------------------------------------------
  // Requests are refused while port 0 is not handed to the bus
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= port_io_pkg::BUS_IDLE;
      cnt_q <= 3'd0;
      hold_q <= '0;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      done_q <= 1'b0;
      case (state_q)
        port_io_pkg::BUS_IDLE:
          if (memReq.go && busEn)
          begin
            hold_q <= memReq; // [RULE_06]
            state_q <= port_io_pkg::BUS_ADDR;
          end
        port_io_pkg::BUS_ADDR:
          state_q <= port_io_pkg::BUS_LATCH;
        port_io_pkg::BUS_LATCH:
        begin
          cnt_q <= 3'd0;
          state_q <= port_io_pkg::BUS_DATA;
        end
        port_io_pkg::BUS_DATA:
          if (cnt_q == port_io_pkg::DATA_CYCLES - 3'd1)
          begin
            done_q <= 1'b1;
            if (!hold_q.write)
              rdata_q <= lvl_q[0];
            state_q <= port_io_pkg::BUS_IDLE;
          end
          else
            cnt_q <= cnt_q + 3'd1;
        default:
          state_q <= port_io_pkg::BUS_IDLE;
      endcase
    end
  end

  assign memBusy = state_q != port_io_pkg::BUS_IDLE;
  assign memDone = done_q;
  assign memRdata = rdata_q;
  assign strobe = state_q == port_io_pkg::BUS_DATA && memEn && !hold_q.fetch;

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Compatibility ports drive only zeros so ones float on pull-ups
  always_comb
  begin
    for (int p = 0; p < 4; p++)
    begin
      out_d[p] = portReg_q[p]; // [RULE_01] [RULE_24]
      oeN_d[p] = dirCfg_q[p] ? portReg_q[p] : 8'h00;
      pull_d[p] = dirCfg_q[p] & ~memBusy; // [RULE_03] [RULE_04]
    end
    ale_d = state_q == port_io_pkg::BUS_ADDR;
    // Port 0 carries address first, then data
    if (memBusy)
    begin
      if (state_q != port_io_pkg::BUS_DATA)
      begin
        out_d[0] = hold_q.addrLow; // [RULE_05] [RULE_07] [RULE_23]
        oeN_d[0] = 8'h00;
      end
      else
      begin
        out_d[0] = hold_q.wdata; // [RULE_05]
        oeN_d[0] = hold_q.write ? 8'h00 : 8'hff;
      end
    end
    // Port 2 high byte only with memory enable set
    if (memBusy && memEn)
    begin
      out_d[2] = (hold_q.fetch || hold_q.viaDptr) ? hold_q.addrHigh
                                                  : memory_page_register_q; // [RULE_14] [RULE_15] [RULE_16]
      oeN_d[2] = 8'h00;
    end
    if (altCfg_q[port_io_pkg::ALT_SER1])
    begin
      out_d[1][3] = altOut.secondaryTx; // [RULE_10]
      oeN_d[1][3] = 1'b0;
    end
    if (altCfg_q[port_io_pkg::ALT_SER0])
    begin
      out_d[3][1] = altOut.primaryTx; // [RULE_17]
      oeN_d[3][1] = 1'b0;
    end
    if (altCfg_q[port_io_pkg::ALT_PWM])
    begin
      out_d[3][3] = altOut.pwm; // [RULE_18]
      oeN_d[3][3] = 1'b0;
    end
    // Strobes idle high while memory enable owns them
    if (memEn)
    begin
      out_d[3][6] = ~(strobe & hold_q.write); // [RULE_20]
      out_d[3][7] = ~(strobe & ~hold_q.write); // [RULE_21]
      oeN_d[3][7:6] = 2'b00;
    end
  end

  // Registered pins; ALE and strobes lag state by one cycle alike
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_q <= {4{port_io_pkg::PORT_RESET}};
      oeN_q <= '1;
      pull_q <= port_io_pkg::DIRCFG_RESET;
      ale_q <= 1'b0;
    end
    else
    begin
      out_q <= out_d;
      oeN_q <= oeN_d;
      pull_q <= pull_d;
      ale_q <= ale_d;
    end
  end

  assign pinOut = out_q;
  assign pinOeN = oeN_q;
  assign pullupEn = pull_q;
  assign ale = ale_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_port1_follow: assert property ( // [RULE_01]
    altCfg_q == 12'h000 && !dirCfg_q[1] |=> pinOut[1] == $past(portReg_q[1]))
    else $error("port 1 pins do not follow register");
  a_pullup_bus_off: assert property ( // [RULE_04]
    memBusy |=> pullupEn == 4'h0)
    else $error("pull-ups on during bus cycle");
  a_ale_addr_hold: assert property ( // [RULE_23]
    $fell(ale) |-> pinOut[0] == $past(pinOut[0]) && pinOeN[0] == 8'h00)
    else $error("address not held at ALE fall");
  a_ale_then_data: assert property ( // [RULE_05]
    state_q == port_io_pkg::BUS_ADDR |-> ##1 ale ##1 !ale ##1
    state_q == port_io_pkg::BUS_DATA ##[1:7] memDone)
    else $error("bus sequence out of order");
  a_write_strobe: assert property ( // [RULE_20]
    strobe && hold_q.write |=> pinOut[3][6] == 1'b0 && pinOut[3][7])
    else $error("write strobe missing");
  a_read_strobe: assert property ( // [RULE_21]
    strobe && !hold_q.write |=> pinOut[3][7] == 1'b0 && pinOut[3][6])
    else $error("read strobe missing");
  a_page_select: assert property ( // [RULE_15]
    memBusy && memEn && !hold_q.viaDptr && !hold_q.fetch
    |=> pinOut[2] == $past(memory_page_register_q))
    else $error("port 2 page byte wrong");
  a_t2_count: assert property ( // [RULE_08]
    altCfg_q[port_io_pkg::ALT_T2_CTR] && fall[1][0] |=> pinEvents.t2Count)
    else $error("timer 2 count pulse missing");
  a_reload_flag: assert property ( // [RULE_09]
    ev_d.t2Reload |=> t2Flag_q && pinEvents.t2Reload)
    else $error("reload flag not set");
  a_irq2_rise: assert property ( // [RULE_11]
    pinEvents.irq2 |-> $past(rise[1][4]))
    else $error("irq two without rising edge");
  a_bus_refused: assert property ( // [RULE_06]
    !memBusy && !busEn |=> !memBusy)
    else $error("bus started while not permitted");

  c_bus_write: cover property (memDone && hold_q.write);
  c_bus_read: cover property (memDone && !hold_q.write);
  c_reload_event: cover property (pinEvents.t2Reload);

endmodule

// [verif/ext_mem_model.sv]
// External memory with address latch, seen through resolved pin levels
`timescale 1ns/1ps
module ext_mem_model (
  // Clock
  input wire logic ref_clk,
  // Pin side
  input wire logic ale,
  input wire logic [3:0][7:0] pinLvl,
  output logic [7:0] memDrv,
  output logic memDrvEn,
  output logic [15:0] addrSeen
);
  logic aleQ;
  logic [7:0] mem [0:65535];

  // Latch takes both address bytes on the falling ALE edge
  always @(posedge ref_clk)
  begin
    aleQ <= ale;
    if (aleQ === 1'b1 && ale === 1'b0)
      addrSeen <= {pinLvl[2], pinLvl[0]};
    if (pinLvl[3][6] === 1'b0)
      mem[addrSeen] <= pinLvl[0];
  end

  // Drives port 0 only while the read strobe is low, released otherwise
  assign memDrvEn = (pinLvl[3][7] === 1'b0);
  assign memDrv = mem[addrSeen];
endmodule

// [verif/quad_port_io_altfunc_tb.sv]
// Self-checking bench for the four-port I/O block
`timescale 1ns/1ps
module quad_port_io_altfunc_tb;
  logic ref_clk = 1'b0;
  logic reset_n, psel, penable, pwrite, errSeen;
  logic [7:0] paddr, memRdata, memDrv;
  logic [31:0] pwdata, prdata, rdv;
  logic pready, pslverr, ale, memBusy, memDone, memDrvEn;
  logic [3:0][7:0] pinLvl, pinOut, pinOeN, extDrv, extEn;
  logic [3:0] pullupEn;
  logic [15:0] addrSeen;
  logic [2:0] v;
  port_io_pkg::memReq_s memReq;
  port_io_pkg::altOut_s altOut;
  port_io_pkg::pinEvents_s pinEvents;
  int err_count = 0;
  int n_checks = 0;
  int i, k;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] v;} regRow_s;
  regRow_s rows [14] = '{'{1'b0, port_io_pkg::ADDR_PORT0, 32'hff},
    '{1'b0, port_io_pkg::ADDR_DIRCFG, 32'hf},
    '{1'b0, port_io_pkg::ADDR_HWCFG, 32'h0},
    '{1'b0, port_io_pkg::ADDR_ALTCFG, 32'h0},
    '{1'b0, port_io_pkg::ADDR_MEMORY_PAGE_REGISTER, 32'h0},
    '{1'b0, port_io_pkg::ADDR_STATUS, 32'h0},
    '{1'b1, port_io_pkg::ADDR_PORT1, 32'h5a},
    '{1'b0, port_io_pkg::ADDR_PORT1, 32'h5a},
    '{1'b1, port_io_pkg::ADDR_PORT3, 32'hc3},
    '{1'b0, port_io_pkg::ADDR_PORT3, 32'hc3},
    '{1'b1, port_io_pkg::ADDR_PORT0, 32'h81},
    '{1'b0, port_io_pkg::ADDR_PORT0, 32'h81},
    '{1'b1, port_io_pkg::ADDR_PORT2, 32'h3c},
    '{1'b0, port_io_pkg::ADDR_PORT2, 32'h3c}};
  int evP [10] = '{1, 1, 1, 1, 1, 1, 3, 3, 3, 3};
  int evB [10] = '{0, 1, 4, 5, 6, 7, 2, 3, 4, 5};
  logic evR [10] = '{0, 0, 1, 0, 1, 0, 0, 0, 0, 0};
  logic [15:0] evM [10] = '{16'h8000, 16'h4000, 16'h0200, 16'h0100,
    16'h0080, 16'h0040, 16'h0800, 16'h0400, 16'h2000, 16'h1000};

  // ------------------------------------------------------------
  // Clock, pin resolution and instances
  // ------------------------------------------------------------
  // 4 ns period
  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end

  // Released lines without pull-up show the inverse level, so a missing
  // drive never reads back right; strobes have board pull-ups
  always_comb
  begin
    for (int p = 0; p < 4; p++)
      for (int b = 0; b < 8; b++)
        if (!pinOeN[p][b])
          pinLvl[p][b] = pinOut[p][b];
        else if (extEn[p][b])
          pinLvl[p][b] = extDrv[p][b];
        else if (p == 0 && memDrvEn)
          pinLvl[p][b] = memDrv[b];
        else if (pullupEn[p] || (p == 3 && b > 5))
          pinLvl[p][b] = 1'b1;
        else
          pinLvl[p][b] = ~pinOut[p][b];
  end

  quad_port_io u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinLvl),
    .pinOut(pinOut), .pinOeN(pinOeN), .pullupEn(pullupEn), .ale(ale),
    .memReq(memReq), .memBusy(memBusy), .memDone(memDone),
    .memRdata(memRdata), .altOut(altOut), .pinEvents(pinEvents));

  ext_mem_model u_mem (.ref_clk(ref_clk), .ale(ale), .pinLvl(pinLvl),
    .memDrv(memDrv), .memDrvEn(memDrvEn), .addrSeen(addrSeen));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task tmo(input string what);
    err_count++;
    $display("mismatch %s expected answer seen timeout", what);
    end_sim;
  endtask

  // Setup, then access held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge ref_clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
      tmo("pready");
    rdv = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Opposite level first gives nothing (a fall only before rise cases), right edge gives one pulse
  task evt(input int p, input int b, input logic rise, input logic [15:0] m);
    int cnt;
    extDrv[p][b] <= !rise;
    cnt = 0;
    repeat (8) @(posedge ref_clk) if ((16'(pinEvents) & m) !== 16'h0) cnt++;
    chk("event on wrong edge", 0, cnt);
    extDrv[p][b] <= rise;
    cnt = 0;
    repeat (8) @(posedge ref_clk) if ((16'(pinEvents) & m) !== 16'h0) cnt++;
    chk("event pulse count", 1, cnt);
  endtask

  // One bus cycle: go for one take edge, then wait for memDone
  task bus(input logic wr, fe, dp, input logic [15:0] ad, input logic [7:0] wd);
    @(posedge ref_clk);
    memReq <= '{1'b1, wr, fe, dp, ad[15:8], ad[7:0], wd};
    @(posedge ref_clk);
    memReq.go <= 1'b0;
    for (k = 0; k < 20; k++)
    begin
      @(posedge ref_clk);
      if (k == 4)
        chk("pull-ups during bus", 0, pullupEn);
      if (memDone === 1'b1)
        break;
    end
    if (k == 20)
      tmo("memDone");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    memReq = '0;
    altOut = '0;
    extDrv = '1;
    extEn = '0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Register rows; a write is also seen at the pins
    for (i = 0; i < 14; i++)
    begin
      apb(rows[i].wr, rows[i].a, rows[i].v);
      repeat (6) @(posedge ref_clk);
      if (rows[i].wr)
        chk("pin level", rows[i].v[7:0], pinLvl[rows[i].a[3:2]]);
      else
        chk("register read", rows[i].v, rdv);
    end
    apb(1'b1, 8'h24, 32'h55);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped read", 0, rdv);
    chk("unmapped error", 1, errSeen);
    apb(1'b1, port_io_pkg::ADDR_DIRCFG, 32'h5);
    repeat (2) @(posedge ref_clk);
    chk("pull-ups by mode", 5, pullupEn);
    apb(1'b1, port_io_pkg::ADDR_DIRCFG, 32'hf);
    $display("test registers done");
    // Edge inputs; release ports 1 and 3 so the far side can move them
    apb(1'b1, port_io_pkg::ADDR_PORT1, 32'hff);
    apb(1'b1, port_io_pkg::ADDR_PORT3, 32'hff);
    extEn[1] <= 8'hf7;
    extEn[3] <= 8'h3d;
    apb(1'b1, port_io_pkg::ADDR_ALTCFG, 32'hfc7);
    for (i = 0; i < 10; i++)
      evt(evP[i], evB[i], evR[i], evM[i]);
    apb(1'b0, port_io_pkg::ADDR_STATUS, 32'h0);
    chk("reload flag", 1, rdv);
    apb(1'b1, port_io_pkg::ADDR_STATUS, 32'h1);
    apb(1'b0, port_io_pkg::ADDR_STATUS, 32'h0);
    chk("flag cleared", 0, rdv);
    $display("test events done");
    // Serial and PWM lines
    extEn[3][3] <= 1'b0;
    apb(1'b1, port_io_pkg::ADDR_ALTCFG, 32'h38);
    for (i = 0; i < 2; i++)
    begin
      v = i ? 3'b010 : 3'b101;
      altOut <= port_io_pkg::altOut_s'(v);
      extDrv[3][0] <= v[2];
      extDrv[1][2] <= v[1];
      repeat (6) @(posedge ref_clk);
      chk("tx lines", v, {pinLvl[3][1], pinLvl[1][3], pinLvl[3][3]});
      chk("rx lines", v[2:1], {pinEvents.primaryRx, pinEvents.secondaryRx});
    end
    $display("test alternate outputs done");
    // External bus
    extEn <= '0;
    apb(1'b1, port_io_pkg::ADDR_HWCFG, 32'h3);
    apb(1'b1, port_io_pkg::ADDR_MEMORY_PAGE_REGISTER, 32'h12);
    bus(1'b1, 1'b0, 1'b0, 16'h0056, 8'ha5);
    chk("page address", 16'h1256, addrSeen);
    chk("written byte", 8'ha5, u_mem.mem[16'h1256]);
    bus(1'b1, 1'b0, 1'b1, 16'h3477, 8'h3c);
    chk("pointer address", 16'h3477, addrSeen);
    bus(1'b0, 1'b0, 1'b1, 16'h3477, 8'h00);
    chk("pointer read", 8'h3c, memRdata);
    bus(1'b0, 1'b0, 1'b0, 16'h0056, 8'h00);
    chk("page read", 8'ha5, memRdata);
    bus(1'b0, 1'b1, 1'b0, 16'h9a0b, 8'h00);
    chk("fetch address", 16'h9a0b, addrSeen);
    apb(1'b1, port_io_pkg::ADDR_HWCFG, 32'h1);
    memReq.go <= 1'b1;
    k = 0;
    repeat (12) @(posedge ref_clk) if (memBusy !== 1'b0) k++;
    chk("bus not permitted", 0, k);
    memReq.go <= 1'b0;
    $display("test external bus done");
    // Mid-run reset
    apb(1'b1, port_io_pkg::ADDR_PORT2, 32'h0);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("reset outputs", 32'hffffffff, pinOut);
    chk("reset enables", 32'hffffffff, pinOeN);
    chk("reset pull-ups", 5'h0f, {ale, pullupEn});
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, port_io_pkg::ADDR_PORT2, 32'h0);
    chk("port after reset", 32'hff, rdv);
    apb(1'b0, port_io_pkg::ADDR_HWCFG, 32'h0);
    chk("config after reset", 32'h0, rdv);
    $display("test reset done");
    end_sim;
  end
endmodule
